// ==== src/gpio_ahb_slave.sv ====
// Purpose: ahb-lite slave front end, turns transfers into strobes
// Assumes: single word transfers, zero wait states
// Notes: read data is muxed by the top from registered state, except extIn which is read straight from the pins
`timescale 1ns/1ps
`default_nettype none
module gpio_ahb_slave
   import gpio_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   gpio_regs_if.slave regs
);
   logic wrPend_reg, wrPend_next;
   logic [7:0] addr_reg, addr_next;
   logic take;

   assign take = hsel & hready & htrans[1];
   assign regs.wrEn = wrPend_reg;
   assign regs.wrAddr = addr_reg;
   assign regs.wrData = hwdata;
   assign regs.rdEn = take & ~hwrite;
   assign regs.rdAddr = haddr[7:0];

   always_comb begin
      wrPend_next = take & hwrite;
      addr_next = take ? haddr[7:0] : addr_reg;
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wrPend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else if (clkEn) begin
         wrPend_reg <= wrPend_next;
         addr_reg <= addr_next;
      end
   end
endmodule
`default_nettype wire

// ==== src/gpio_pkg.sv ====
// Purpose: shared constants and types for the general i/o port block
// Assumes: 32-bit single-word ahb-lite register access
// Notes: offsets are byte addresses
package gpio_pkg;
   localparam logic [7:0] GPIO_OUT_ADDR = 8'h00;
   localparam logic [7:0] GPIO_BITOP_ADDR = 8'h04;
   localparam logic [7:0] GPIO_IN_ADDR = 8'h08;
   localparam logic [7:0] GPIO_WAIT_ADDR = 8'h0C;
   localparam logic [7:0] GPIO_IRQCFG_ADDR = 8'h10;
   localparam logic [7:0] GPIO_CTRL_ADDR = 8'h14;
   localparam logic [7:0] GPIO_STAT_ADDR = 8'h18;
   localparam logic [7:0] GPIO_EXTDIR_ADDR = 8'h1C;
   localparam logic [7:0] GPIO_EXTOUT_ADDR = 8'h20;
   localparam logic [7:0] GPIO_EXTIN_ADDR = 8'h24;
   localparam logic [7:0] GPIO_AN1_ADDR = 8'h28;
   localparam logic [7:0] GPIO_AN2_ADDR = 8'h2C;
   localparam int GPIO_OUT_W = 8;
   localparam int GPIO_IN_W = 8;
   localparam int GPIO_EXT_W = 64;
   localparam int GPIO_EXT_GRP = 8;
   localparam int GPIO_AN_W = 12;
   localparam logic [7:0] GPIO_OUT_RST = 8'h00;
   localparam logic [7:0] GPIO_MASK_RST = 8'h00;
   localparam logic [7:0] GPIO_EXTDIR_RST = 8'h00;
   // bitop register fields
   localparam int GPIO_BITOP_IDX_LSB = 0;
   localparam int GPIO_BITOP_CMD_LSB = 4;
   localparam int GPIO_BITOP_VAL_LSB = 8;
   // bitop commands
   localparam logic [1:0] GPIO_CMD_SET = 2'h1;
   localparam logic [1:0] GPIO_CMD_CLR = 2'h2;
   localparam logic [1:0] GPIO_CMD_COND = 2'h3;
   // ctrl register bits; range sits at bit 16 + GPIO_CTRL_RANGE of irqcfg
   localparam int GPIO_CTRL_RET = 0;
   localparam int GPIO_CTRL_DISCARD = 1;
   localparam int GPIO_CTRL_RANGE = 2;
   typedef enum logic [1:0] {
      GPIO_IDLE,
      GPIO_WAITING,
      GPIO_SERVICE
   } gpio_state_t;
endpackage

// ==== src/gpio_port.sv ====
// Purpose: general i/o port with input interrupt, wait and analog readout
// Assumes: pins synchronous to mclk; adc supplies 12-bit samples
// Notes: program sequencer is outside; this block gives status and strobes
// Contract
// - three outputs individually set or cleared
// - conditional bit: nonzero sets, zero clears
// - whole port write, bit0 is output 1
// - whole write replaces all port bits
// - input read returns present pin level
// - wait stalls until input reaches level
// - interrupt range from first to last input
// - mask form: bit k enables input k+1
// - low enabled input enters interrupt service
// - return resumes saved execution point
// - discard drops saved return context
// - two 12-bit analog inputs readable
// - 64 extended points, direction per eight
`timescale 1ns/1ps
`default_nettype none
module gpio_port
   import gpio_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] inPins,
   input wire logic [11:0] anIn1,
   input wire logic [11:0] anIn2,
   input wire logic [15:0] resumePc,
   output logic [7:0] outPins,
   output logic [63:0] extOut,
   output logic [63:0] extOutEnN,
   input wire logic [63:0] extIn,
   output logic stall,
   output logic intEntry,
   output logic [15:0] returnPc,
   output logic returnValid,
   output logic resumeStrobe
);
   gpio_regs_if regs();

   gpio_ahb_slave u_slave (
      .mclk(mclk),
      .rstn(rstn),
      .clkEn(clkEn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hwdata(hwdata),
      .regs(regs)
   );

   logic [7:0] out_reg, out_next;
   logic [7:0] mask_reg, mask_next;
   logic [7:0] extDir_reg, extDir_next;
   logic [63:0] extOut_reg, extOut_next;
   logic [63:0] extOe_next;
   logic [31:0] rd_reg, rd_next;
   logic [7:0] inPins_reg;
   logic [11:0] an1_reg, an2_reg;
   logic [2:0] waitIdx_reg, waitIdx_next;
   logic waitLevel_reg, waitLevel_next;
   gpio_state_t state_reg, state_next;
   logic [15:0] retPc_reg, retPc_next;
   logic retValid_reg, retValid_next;
   logic entry_next;
   logic resume_next;
   logic stall_reg, stall_next;

   logic [2:0] bitIdx;
   logic [1:0] bitCmd;
   logic [23:0] bitVal;
   logic [2:0] first, last;
   logic [7:0] rangeMask;
   logic wrOut, wrBit, wrWait, wrCfg, wrCtrl, wrDir, wrExt;
   logic intHit, waitMet;

   assign bitIdx = regs.wrData[GPIO_BITOP_IDX_LSB +: 3];
   assign bitCmd = regs.wrData[GPIO_BITOP_CMD_LSB +: 2];
   assign bitVal = regs.wrData[GPIO_BITOP_VAL_LSB +: 24];
   assign first = regs.wrData[2:0];
   assign last = regs.wrData[10:8];
   assign wrOut = regs.wrEn && regs.wrAddr == GPIO_OUT_ADDR;
   assign wrBit = regs.wrEn && regs.wrAddr == GPIO_BITOP_ADDR;
   assign wrWait = regs.wrEn && regs.wrAddr == GPIO_WAIT_ADDR;
   assign wrCfg = regs.wrEn && regs.wrAddr == GPIO_IRQCFG_ADDR;
   assign wrCtrl = regs.wrEn && regs.wrAddr == GPIO_CTRL_ADDR;
   assign wrDir = regs.wrEn && regs.wrAddr == GPIO_EXTDIR_ADDR;
   assign wrExt = regs.wrEn && regs.wrAddr == GPIO_EXTOUT_ADDR;
   assign intHit = |(mask_reg & ~inPins_reg);
   assign waitMet = inPins_reg[waitIdx_reg] == waitLevel_reg;

   // range to mask, inclusive
   always_comb begin
      rangeMask = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (i >= int'(first) && i <= int'(last)) begin
            rangeMask[i] = 1'b1;
         end
      end
   end

   // output port and configuration registers
   always_comb begin
      out_next = out_reg;
      mask_next = mask_reg;
      extDir_next = extDir_reg;
      extOut_next = extOut_reg;
      if (wrOut) begin
         out_next = regs.wrData[7:0];
      end
      if (wrBit) begin
         unique case (bitCmd)
            GPIO_CMD_SET: out_next[bitIdx] = 1'b1;
            GPIO_CMD_CLR: out_next[bitIdx] = 1'b0;
            GPIO_CMD_COND: out_next[bitIdx] = |bitVal;
            default: out_next = out_reg;
         endcase
      end
      if (wrCfg) begin
         if (regs.wrData[16 + GPIO_CTRL_RANGE]) begin
            mask_next = rangeMask;
         end else begin
            mask_next = regs.wrData[31:24];
         end
      end
      if (wrDir) begin
         extDir_next = regs.wrData[7:0];
      end
      if (wrExt) begin
         extOut_next = {regs.wrData, regs.wrData};
      end
      for (int g = 0; g < GPIO_EXT_W / GPIO_EXT_GRP; g++) begin
         extOe_next[g * 8 +: 8] = {8{~extDir_next[g]}};
      end
   end

   // wait, interrupt entry, return and discard
   always_comb begin
      state_next = state_reg;
      waitIdx_next = waitIdx_reg;
      waitLevel_next = waitLevel_reg;
      retPc_next = retPc_reg;
      retValid_next = retValid_reg;
      entry_next = 1'b0;
      resume_next = 1'b0;
      stall_next = 1'b0;
      unique case (state_reg)
         GPIO_IDLE: begin
            if (intHit) begin
               state_next = GPIO_SERVICE;
               retPc_next = resumePc;
               retValid_next = 1'b1;
               entry_next = 1'b1;
            end else if (wrWait) begin
               waitIdx_next = regs.wrData[2:0];
               waitLevel_next = ~regs.wrData[31];
               state_next = GPIO_WAITING;
               stall_next = 1'b1;
            end
         end
         GPIO_WAITING: begin
            if (waitMet) begin
               state_next = GPIO_IDLE;
            end else begin
               stall_next = 1'b1;
            end
         end
         GPIO_SERVICE: begin
            if (wrCtrl && regs.wrData[GPIO_CTRL_RET]) begin
               state_next = GPIO_IDLE;
               resume_next = retValid_reg;
               retValid_next = 1'b0;
            end else if (wrCtrl && regs.wrData[GPIO_CTRL_DISCARD]) begin
               state_next = GPIO_IDLE;
               retValid_next = 1'b0;
            end
         end
         default: state_next = GPIO_IDLE;
      endcase
   end

   // read mux
   always_comb begin
      rd_next = 32'h00000000;
      unique case (regs.rdAddr)
         GPIO_OUT_ADDR: rd_next = {24'h000000, out_reg};
         GPIO_IN_ADDR: rd_next = {24'h000000, inPins_reg};
         GPIO_IRQCFG_ADDR: rd_next = {mask_reg, 24'h000000};
         GPIO_STAT_ADDR: rd_next = {retPc_reg, 13'h0000, retValid_reg, stall_reg, state_reg == GPIO_SERVICE};
         GPIO_EXTDIR_ADDR: rd_next = {24'h000000, extDir_reg};
         GPIO_EXTIN_ADDR: rd_next = extIn[31:0];
         GPIO_AN1_ADDR: rd_next = {20'h00000, an1_reg};
         GPIO_AN2_ADDR: rd_next = {20'h00000, an2_reg};
         default: rd_next = 32'h00000000;
      endcase
      if (!regs.rdEn) begin
         rd_next = rd_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         out_reg <= GPIO_OUT_RST;
         mask_reg <= GPIO_MASK_RST;
         extDir_reg <= GPIO_EXTDIR_RST;
         extOut_reg <= 64'h0000000000000000;
         rd_reg <= 32'h00000000;
         inPins_reg <= 8'hFF;
         an1_reg <= 12'h000;
         an2_reg <= 12'h000;
         waitIdx_reg <= 3'h0;
         waitLevel_reg <= 1'b0;
         state_reg <= GPIO_IDLE;
         retPc_reg <= 16'h0000;
         retValid_reg <= 1'b0;
         stall_reg <= 1'b0;
      end else if (clkEn) begin
         out_reg <= out_next;
         mask_reg <= mask_next;
         extDir_reg <= extDir_next;
         extOut_reg <= extOut_next;
         rd_reg <= rd_next;
         inPins_reg <= inPins;
         an1_reg <= anIn1;
         an2_reg <= anIn2;
         waitIdx_reg <= waitIdx_next;
         waitLevel_reg <= waitLevel_next;
         state_reg <= state_next;
         retPc_reg <= retPc_next;
         retValid_reg <= retValid_next;
         stall_reg <= stall_next;
      end
   end

   // only three low bits reach pins
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         outPins <= 8'h00;
         extOut <= 64'h0000000000000000;
         extOutEnN <= 64'hFFFFFFFFFFFFFFFF;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         stall <= 1'b0;
         intEntry <= 1'b0;
         returnPc <= 16'h0000;
         returnValid <= 1'b0;
         resumeStrobe <= 1'b0;
      end else if (clkEn) begin
         outPins <= {5'h00, out_next[2:0]};
         extOut <= extOut_next;
         extOutEnN <= extOe_next;
         hrdata <= rd_next;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         stall <= stall_next;
         intEntry <= entry_next;
         returnPc <= retPc_next;
         returnValid <= retValid_next;
         resumeStrobe <= resume_next;
      end
   end
endmodule
`default_nettype wire

// ==== src/gpio_regs_if.sv ====
// Purpose: register write and read strobes from bus slave to core logic
// Assumes: one clock domain
// Notes: strobes last one cycle
`timescale 1ns/1ps
`default_nettype none
interface gpio_regs_if;
   logic wrEn;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic rdEn;
   logic [7:0] rdAddr;
   modport slave (output wrEn, output wrAddr, output wrData, output rdEn, output rdAddr);
   modport core (input wrEn, input wrAddr, input wrData, input rdEn, input rdAddr);
endinterface
`default_nettype wire

// ==== tb/gpio_field_model.sv ====
// Purpose: switches and sensors driving the general inputs
// Assumes: levels change only on mclk
// Notes: one register of settle delay
`timescale 1ns/1ps
`default_nettype none
module gpio_field_model
(
   input wire logic mclk,
   input wire logic [7:0] level,
   output logic [7:0] inPins
);
   always_ff @(posedge mclk) begin
      inPins <= level;
   end
endmodule
`default_nettype wire

// ==== tb/gpio_port_checker.sv ====
// Purpose: port-level assertions for the general i/o port
// Assumes: clkEn held high
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module gpio_port_checker
   import gpio_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [7:0] inPins,
   input wire logic [7:0] outPins,
   input wire logic stall,
   input wire logic intEntry,
   input wire logic returnValid,
   input wire logic resumeStrobe
);
   logic wrOut;
   logic rdIn;
   wire take = hsel && hready && htrans[1];
   always_ff @(posedge mclk) begin
      wrOut <= rstn && take && hwrite && haddr[7:0] == GPIO_OUT_ADDR;
      rdIn <= rstn && take && !hwrite && haddr[7:0] == GPIO_IN_ADDR;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_upper_zero: assert property (outPins[7:3] == 5'h00)
      else $error("unused port bits driven");
   a_port_write: assert property (wrOut |=> outPins == ($past(hwdata[7:0]) & 8'h07))
      else $error("port write not applied");
   a_input_read: assert property (rdIn && $past(inPins, 1) == $past(inPins, 2) |-> hrdata == {24'h0, $past(inPins)})
      else $error("input read wrong");
   a_entry_low: assert property (intEntry |-> ($past(inPins, 1) & $past(inPins, 2) & $past(inPins, 3)) != 8'hFF)
      else $error("entry without low input");
   a_entry_pulse: assert property (intEntry |=> !intEntry)
      else $error("entry pulse too long");
   a_resume_pulse: assert property (resumeStrobe |=> !resumeStrobe)
      else $error("resume pulse too long");
   a_resume_ctx: assert property (resumeStrobe |-> $past(returnValid))
      else $error("resume without saved point");
   a_reset_clear: assert property (disable iff (1'b0) !rstn |=> outPins == 8'h00 && !stall && !returnValid)
      else $error("reset state wrong");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or error response");
   c_entry: cover property (intEntry);
   c_resume: cover property (resumeStrobe);
   c_stall: cover property ($fell(stall));
endmodule
bind gpio_port gpio_port_checker u_chk (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .inPins(inPins), .outPins(outPins),
   .stall(stall), .intEntry(intEntry), .returnValid(returnValid), .resumeStrobe(resumeStrobe));
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the general i/o port
// Assumes: zero wait slave, inputs through field model
// Notes: fixed seed random stimulus
`timescale 1ns/1ps
`default_nettype none
module testbench import gpio_pkg::*;;
   logic mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [7:0] level = 8'hFF, outPins, inPins, expOut;
   logic [11:0] an1 = 12'h0, an2 = 12'h0;
   logic [15:0] pc = 16'h0, returnPc;
   logic [63:0] extIn = 64'h0, extOut, extOutEnN;
   logic hreadyout, hresp, stall, intEntry, returnValid, resumeStrobe;
   integer seed = 32'h18F998E4;
   int error_cnt = 0, n_compared = 0, nEntry = 0, nResume = 0;
   int cmds[4] = '{1, 3, 2, 3};
   gpio_port u_dut (.mclk(mclk), .rstn(rstn), .clkEn(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .inPins(inPins), .anIn1(an1), .anIn2(an2), .resumePc(pc), .outPins(outPins),
      .extOut(extOut), .extOutEnN(extOutEnN), .extIn(extIn), .stall(stall), .intEntry(intEntry),
      .returnPc(returnPc), .returnValid(returnValid), .resumeStrobe(resumeStrobe));
   gpio_field_model u_field (.mclk(mclk), .level(level), .inPins(inPins));
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (intEntry === 1'b1) nEntry <= nEntry + 1;
      if (resumeStrobe === 1'b1) nResume <= nResume + 1;
   end
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge mclk);
         rd = hrdata;
      end while (hreadyout !== 1'b1);
      #1;
   endtask
   function automatic logic [63:0] enExp(input logic [7:0] dir);
      logic [63:0] e;
      e = 64'h0;
      for (int g = 0; g < 8; g++) begin
         e[g * 8 +: 8] = dir[g] ? 8'h00 : 8'hFF;
      end
      return e;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   function automatic logic [7:0] bitExp(input logic [7:0] cur, input int i, input int c, input logic [23:0] v);
      logic on;
      on = c == 1 || (c == 3 && v != 24'h0);
      return on ? cur | (8'h01 << i) : cur & ~(8'h01 << i);
   endfunction
   task automatic conclude();
      $display("errors=%0d compared=%0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #500000;
      error_cnt++;
      conclude();
   end
   initial begin
      logic [31:0] r;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      tick(1);
      check(outPins, 8'h00);
      xfer(1'b0, GPIO_IRQCFG_ADDR, 32'h0);
      check(rd[31:24], 8'h00);
      xfer(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      for (int i = 0; i < 8; i++) begin
         expOut = i == 0 ? 8'h06 : i == 1 ? 8'h00 : i == 2 ? 8'hFF : 8'($random(seed));
         xfer(1'b1, GPIO_OUT_ADDR, {24'h0, expOut});
         expOut = expOut & 8'h07;
         check(outPins, expOut);
      end
      for (int j = 0; j < 4; j++) begin
         for (int i = 0; i < 3; i++) begin
            r = (j == 1 && i == 1) ? 32'h0 : 32'($random(seed));
            xfer(1'b1, GPIO_BITOP_ADDR, {r[23:0], 2'h0, cmds[j][1:0], 1'b0, 3'(i)});
            expOut = bitExp(expOut, i, cmds[j], r[23:0]);
            check(outPins, expOut);
         end
      end
      repeat (4) begin
         level <= 8'($random(seed));
         an1 <= 12'($random(seed));
         an2 <= 12'($random(seed));
         extIn <= {32'($random(seed)), 32'($random(seed))};
         tick(3);
         xfer(1'b0, GPIO_IN_ADDR, 32'h0);
         check(rd, {24'h0, level});
         xfer(1'b0, GPIO_AN1_ADDR, 32'h0);
         check(rd, {20'h0, an1});
         xfer(1'b0, GPIO_AN2_ADDR, 32'h0);
         check(rd, {20'h0, an2});
         xfer(1'b0, GPIO_EXTIN_ADDR, 32'h0);
         check(rd, extIn[31:0]);
      end
      check(extOutEnN, 64'hFFFFFFFFFFFFFFFF);
      r = 32'($random(seed));
      xfer(1'b1, GPIO_EXTDIR_ADDR, {24'h0, r[7:0]});
      check(extOutEnN, enExp(r[7:0]));
      xfer(1'b0, GPIO_EXTDIR_ADDR, 32'h0);
      check(rd, {24'h0, r[7:0]});
      xfer(1'b1, GPIO_EXTOUT_ADDR, ~r);
      check(extOut, {~r, ~r});
      for (int k = 0; k < 2; k++) begin
         level <= k ? 8'hFF : 8'hFB;
         tick(3);
         xfer(1'b1, GPIO_WAIT_ADDR, {k[0], 31'h2});
         tick(2);
         check(stall, 1'b1);
         level <= k ? 8'hFB : 8'hFF;
         tick(5);
         check(stall, 1'b0);
      end
      level <= 8'hFF;
      pc <= 16'($random(seed));
      tick(3);
      xfer(1'b1, GPIO_IRQCFG_ADDR, 32'h05000000);
      xfer(1'b0, GPIO_IRQCFG_ADDR, 32'h0);
      check(rd[31:24], 8'h05);
      level <= 8'hFD;
      tick(5);
      check(nEntry, 0);
      level <= 8'hFB;
      tick(5);
      check(nEntry, 1);
      xfer(1'b0, GPIO_STAT_ADDR, 32'h0);
      check({rd[31:16], rd[2], rd[0]}, {pc, 2'h3});
      check(returnPc, pc);
      level <= 8'hFF;
      tick(3);
      xfer(1'b1, GPIO_CTRL_ADDR, 32'h1);
      tick(3);
      check(nResume, 1);
      xfer(1'b1, GPIO_IRQCFG_ADDR, 32'h00040301);
      xfer(1'b0, GPIO_IRQCFG_ADDR, 32'h0);
      check(rd[31:24], 8'h0E);
      level <= 8'hEF;
      tick(5);
      check(nEntry, 1);
      level <= 8'hF7;
      tick(5);
      check(nEntry, 2);
      level <= 8'hFF;
      tick(3);
      xfer(1'b1, GPIO_CTRL_ADDR, 32'h2);
      tick(2);
      xfer(1'b0, GPIO_STAT_ADDR, 32'h0);
      check({rd[2], rd[0]}, 2'h0);
      check(nResume, 1);
      xfer(1'b1, GPIO_OUT_ADDR, 32'h7);
      check(outPins, 8'h07);
      rstn <= 1'b0;
      tick(3);
      rstn <= 1'b1;
      tick(1);
      check(outPins, 8'h00);
      check(extOutEnN, 64'hFFFFFFFFFFFFFFFF);
      xfer(1'b0, GPIO_IRQCFG_ADDR, 32'h0);
      check(rd[31:24], 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
